//--- design/srl_pulse_gen.sv
// periodic pulse generator: one clock wide pulse every selected period.
// assumes a free running pclk and a select held stable by software.
`timescale 1ns/1ns
`default_nettype none

module srl_pulse_gen
  import srl_pkg::*;
#(
  parameter int CNT_W = `SRL_DIV_CNT_W,
  parameter int SEL_W = `SRL_DIV_SEL_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // divider select and pulse out
  input wire logic [SEL_W-1:0] sel,
  output logic pulse
);

  srl_pgen_state_type st_q;
  srl_pgen_state_type st_d;

  // last count of a period for a given select
  function automatic logic [CNT_W-1:0] last_count(input logic [SEL_W-1:0] s);
    logic [CNT_W:0] n;
    n = (CNT_W+1)'(`SRL_DIV_MIN) << s;
    return CNT_W'(n - (CNT_W+1)'(1));
  endfunction

  // count 0..N-1 and flag the last count; a shortened select wraps at once
  always_comb begin
    st_d = st_q;
    if (st_q.cnt >= last_count(sel)) begin
      st_d.cnt = '0;
      st_d.pulse = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + CNT_W'(1);
      st_d.pulse = 1'b0;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pulse = st_q.pulse;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_pulse_one_wide;
    @(posedge pclk) disable iff (!presetn)
    st_q.pulse |=> !st_q.pulse;
  endproperty
  a_pulse_one_wide: assert property (p_pulse_one_wide)
    else $error("periodic pulse wider than one cycle");

  property p_period_four;
    @(posedge pclk) disable iff (!presetn)
    (st_q.pulse && sel == '0) ##1 (sel == '0)[*3] |=> st_q.pulse && $past(!st_q.pulse);
  endproperty
  a_period_four: assert property (p_period_four)
    else $error("periodic pulse not every fourth cycle");

endmodule // srl_pulse_gen

`default_nettype wire

//--- design/srl_top.sv
// set-reset latch unit with apb register access, periodic pulse source,
// synchronised pin and comparator inputs and gated pin outputs.
// assumes an apb master on pclk; pin and comparator inputs are asynchronous;
// the port direction logic outside decides whether the pins really drive.
`timescale 1ns/1ns
`default_nettype none

module srl_top
  import srl_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // asynchronous latch sources
  input wire logic latch_input_pin,
  input wire logic cmp1_out,
  input wire logic cmp2_out,
  // latch outputs toward the pins
  output logic true_output_pin,
  output logic true_output_drive,
  output logic complement_output_pin,
  output logic complement_output_drive,
  output logic latch_state
);

  // ****************************************************************
  // state and helpers
  // ****************************************************************
  srl_state_type st_q;
  srl_state_type st_d;
  logic periodic_pulse;
  logic set_eff;
  logic rst_eff;
  logic access;
  logic commit_wr;
  logic commit_rd;

  // byte address match for one register offset
  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
    return a == ADDR_W'(ofs);
  endfunction

  // one step of the three-stage synchroniser; the filter only reads stages two and three
  function automatic srl_sync_type sync_step(input srl_sync_type s, input logic in);
    srl_sync_type n;
    n.s1 = in;
    n.s2 = s.s1;
    n.s3 = s.s2;
    n.f = (s.s2 == s.s3) ? s.s3 : s.f;
    return n;
  endfunction

  // or of the enabled set sources, firmware pulse included
  function automatic logic set_sources(input srl_state_type s, input logic pls);
    logic r;
    r = s.fw_set;
    r = r | (s.src[`SRL_SRC_PIN_SET_BIT] & s.pin.f);
    r = r | (s.src[`SRL_SRC_PULSE_SET_BIT] & pls);
    r = r | (s.src[`SRL_SRC_CMP2_SET_BIT] & s.cmp2.f);
    r = r | (s.src[`SRL_SRC_CMP1_SET_BIT] & s.cmp1.f);
    return r;
  endfunction

  // or of the enabled reset sources, firmware pulse included
  function automatic logic rst_sources(input srl_state_type s, input logic pls);
    logic r;
    r = s.fw_rst;
    r = r | (s.src[`SRL_SRC_PIN_RST_BIT] & s.pin.f);
    r = r | (s.src[`SRL_SRC_PULSE_RST_BIT] & pls);
    r = r | (s.src[`SRL_SRC_CMP2_RST_BIT] & s.cmp2.f);
    r = r | (s.src[`SRL_SRC_CMP1_RST_BIT] & s.cmp1.f);
    return r;
  endfunction

  // ****************************************************************
  // periodic pulse source
  // ****************************************************************
  srl_pulse_gen #(
    .CNT_W(`SRL_DIV_CNT_W),
    .SEL_W(`SRL_DIV_SEL_W)
  ) u_pulse_gen (
    .pclk(pclk),
    .presetn(presetn),
    .sel(st_q.ctrl[`SRL_CTRL_DIV_MSB:`SRL_CTRL_DIV_LSB]),
    .pulse(periodic_pulse)
  );

  // ****************************************************************
  // bus phase decode
  // ****************************************************************
  // one wait state: the answer is prepared in the first access cycle
  assign access = psel & penable;
  assign commit_wr = access & st_q.pready & pwrite & !st_q.pslverr;
  assign commit_rd = access & st_q.pready & !pwrite;

  // effective latch inputs, both active high
  assign set_eff = set_sources(st_q, periodic_pulse);
  assign rst_eff = rst_sources(st_q, periodic_pulse);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_d = st_q;
    // input synchronisers
    st_d.pin = sync_step(st_q.pin, latch_input_pin);
    st_d.cmp1 = sync_step(st_q.cmp1, cmp1_out);
    st_d.cmp2 = sync_step(st_q.cmp2, cmp2_out);
    // firmware pulses last one cycle unless written again
    st_d.fw_set = 1'b0;
    st_d.fw_rst = 1'b0;
    // apb answer prepared in the first access cycle
    st_d.pready = 1'b0;
    st_d.pslverr = 1'b0;
    st_d.prdata = '0;
    if (access && !st_q.pready) begin
      st_d.pready = 1'b1;
      if (addr_is(paddr, `SRL_OFS_CTRL)) begin
        st_d.prdata[7:0] = st_q.ctrl;
        st_d.prdata[`SRL_CTRL_FWSET_BIT] = 1'b0;
        st_d.prdata[`SRL_CTRL_FWRST_BIT] = 1'b0;
      end else if (addr_is(paddr, `SRL_OFS_SRC)) begin
        st_d.prdata[7:0] = st_q.src;
      end else if (addr_is(paddr, `SRL_OFS_STAT)) begin
        st_d.prdata[`SRL_STAT_LATCH_BIT] = st_q.latch;
      end else begin
        st_d.pslverr = 1'b1;
      end
    end
    // register writes take effect at the completing edge
    if (commit_wr) begin
      if (addr_is(paddr, `SRL_OFS_CTRL)) begin
        st_d.ctrl = pwdata[7:0];
        st_d.ctrl[`SRL_CTRL_FWSET_BIT] = 1'b0;
        st_d.ctrl[`SRL_CTRL_FWRST_BIT] = 1'b0;
        st_d.fw_set = pwdata[`SRL_CTRL_FWSET_BIT];
        st_d.fw_rst = pwdata[`SRL_CTRL_FWRST_BIT];
      end else if (addr_is(paddr, `SRL_OFS_SRC)) begin
        st_d.src = pwdata[7:0];
      end
    end
    // latch storage, reset dominant, frozen while disabled
    if (st_q.ctrl[`SRL_CTRL_EN_BIT]) begin
      if (rst_eff) begin
        st_d.latch = 1'b0;
      end else if (set_eff) begin
        st_d.latch = 1'b1;
      end
    end
    // pin values follow the latch, routing follows the enables
    st_d.true_pin = st_q.latch;
    st_d.comp_pin = !st_q.latch;
    st_d.true_drive = st_q.ctrl[`SRL_CTRL_EN_BIT] & st_q.ctrl[`SRL_CTRL_QEN_BIT];
    st_d.comp_drive = st_q.ctrl[`SRL_CTRL_EN_BIT] & st_q.ctrl[`SRL_CTRL_NQEN_BIT];
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // the latch gets a constant only so simulation starts clean; software
  // must not rely on it and forces the latch before routing it out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.ctrl <= `SRL_CTRL_RESET;
      st_q.src <= `SRL_SRC_RESET;
      st_q.latch <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign true_output_pin = st_q.true_pin;
  assign true_output_drive = st_q.true_drive;
  assign complement_output_pin = st_q.comp_pin;
  assign complement_output_drive = st_q.comp_drive;
  assign latch_state = st_q.latch;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_disabled_outputs_off;
    @(posedge pclk) disable iff (!presetn)
    !st_q.ctrl[`SRL_CTRL_EN_BIT] |=> !true_output_drive && !complement_output_drive;
  endproperty
  a_disabled_outputs_off: assert property (p_disabled_outputs_off)
    else $error("output routed while latch disabled");

  property p_true_route;
    @(posedge pclk) disable iff (!presetn)
    st_q.ctrl[`SRL_CTRL_EN_BIT] && st_q.ctrl[`SRL_CTRL_QEN_BIT]
      |=> true_output_drive && (true_output_pin == $past(st_q.latch));
  endproperty
  a_true_route: assert property (p_true_route)
    else $error("true output not routed with latch value");

  property p_comp_route;
    @(posedge pclk) disable iff (!presetn)
    st_q.ctrl[`SRL_CTRL_EN_BIT] && st_q.ctrl[`SRL_CTRL_NQEN_BIT]
      |=> complement_output_drive && (complement_output_pin != $past(st_q.latch));
  endproperty
  a_comp_route: assert property (p_comp_route)
    else $error("complement output not routed with inverted latch value");

  property p_fw_set_pulse;
    @(posedge pclk) disable iff (!presetn)
    commit_wr && addr_is(paddr, `SRL_OFS_CTRL) && pwdata[`SRL_CTRL_FWSET_BIT]
      |=> st_q.fw_set ##1 !st_q.fw_set;
  endproperty
  a_fw_set_pulse: assert property (p_fw_set_pulse)
    else $error("firmware set pulse not exactly one cycle");

  property p_fw_rst_pulse;
    @(posedge pclk) disable iff (!presetn)
    commit_wr && addr_is(paddr, `SRL_OFS_CTRL) && pwdata[`SRL_CTRL_FWRST_BIT]
      |=> st_q.fw_rst ##1 !st_q.fw_rst;
  endproperty
  a_fw_rst_pulse: assert property (p_fw_rst_pulse)
    else $error("firmware reset pulse not exactly one cycle");

  property p_pulse_bits_read_zero;
    @(posedge pclk) disable iff (!presetn)
    commit_rd && addr_is(paddr, `SRL_OFS_CTRL) |-> prdata[1:0] == 2'h0;
  endproperty
  a_pulse_bits_read_zero: assert property (p_pulse_bits_read_zero)
    else $error("pulse bits read back nonzero");

  property p_reset_dominant;
    @(posedge pclk) disable iff (!presetn)
    st_q.ctrl[`SRL_CTRL_EN_BIT] && set_eff && rst_eff |=> !latch_state;
  endproperty
  a_reset_dominant: assert property (p_reset_dominant)
    else $error("latch not reset when set and reset both high");

  property p_pin_sets_latch;
    @(posedge pclk) disable iff (!presetn)
    st_q.ctrl[`SRL_CTRL_EN_BIT] && st_q.src[`SRL_SRC_PIN_SET_BIT] && st_q.pin.f && !rst_eff
      |=> latch_state;
  endproperty
  a_pin_sets_latch: assert property (p_pin_sets_latch)
    else $error("enabled input pin failed to set latch");

  property p_cmp1_resets_latch;
    @(posedge pclk) disable iff (!presetn)
    st_q.ctrl[`SRL_CTRL_EN_BIT] && st_q.src[`SRL_SRC_CMP1_RST_BIT] && st_q.cmp1.f
      |=> !latch_state;
  endproperty
  a_cmp1_resets_latch: assert property (p_cmp1_resets_latch)
    else $error("enabled comparator 1 failed to reset latch");

  property p_latch_holds;
    @(posedge pclk) disable iff (!presetn)
    !set_eff && !rst_eff |=> $stable(latch_state);
  endproperty
  a_latch_holds: assert property (p_latch_holds)
    else $error("latch changed with no active source");

  property p_bus_answer;
    @(posedge pclk) disable iff (!presetn)
    access && !pready |=> pready ##1 !pready;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("apb answer not one wait state");

endmodule // srl_top

`default_nettype wire

//--- shared/srl_params.svh
// constants for the set-reset latch unit: register offsets, field positions,
// reset values and divider figures.
// assumes it is included by bare name from the package and testbench files.
`ifndef SRL_PARAMS_SVH
`define SRL_PARAMS_SVH

// ****************************************************************
// register byte offsets on the apb bus
// ****************************************************************
`define SRL_OFS_CTRL 12'h000
`define SRL_OFS_SRC 12'h004
`define SRL_OFS_STAT 12'h008

// ****************************************************************
// primary control register fields
// ****************************************************************
`define SRL_CTRL_EN_BIT 7
`define SRL_CTRL_DIV_MSB 6
`define SRL_CTRL_DIV_LSB 4
`define SRL_CTRL_QEN_BIT 3
`define SRL_CTRL_NQEN_BIT 2
`define SRL_CTRL_FWSET_BIT 1
`define SRL_CTRL_FWRST_BIT 0

// ****************************************************************
// source enable register fields
// ****************************************************************
`define SRL_SRC_PIN_SET_BIT 7
`define SRL_SRC_PULSE_SET_BIT 6
`define SRL_SRC_CMP2_SET_BIT 5
`define SRL_SRC_CMP1_SET_BIT 4
`define SRL_SRC_PIN_RST_BIT 3
`define SRL_SRC_PULSE_RST_BIT 2
`define SRL_SRC_CMP2_RST_BIT 1
`define SRL_SRC_CMP1_RST_BIT 0

// ****************************************************************
// status register field and reset values
// ****************************************************************
`define SRL_STAT_LATCH_BIT 0
`define SRL_CTRL_RESET 8'h00
`define SRL_SRC_RESET 8'h00

// ****************************************************************
// periodic pulse divider: period is min times two to the select
// ****************************************************************
`define SRL_DIV_MIN 4
`define SRL_DIV_SEL_W 3
`define SRL_DIV_CNT_W 9

`endif

//--- shared/srl_pkg.sv
// types shared by the set-reset latch unit files.
// assumes the params header is on the include path.
`include "srl_params.svh"

package srl_pkg;

  // ****************************************************************
  // three-stage input synchroniser with agreement filter
  // ****************************************************************
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic f;
  } srl_sync_type;

  // ****************************************************************
  // whole state of the top module
  // ****************************************************************
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] src;
    logic fw_set;
    logic fw_rst;
    srl_sync_type pin;
    srl_sync_type cmp1;
    srl_sync_type cmp2;
    logic latch;
    logic true_pin;
    logic comp_pin;
    logic true_drive;
    logic comp_drive;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } srl_state_type;

  // ****************************************************************
  // whole state of the pulse generator
  // ****************************************************************
  typedef struct packed {
    logic [`SRL_DIV_CNT_W-1:0] cnt;
    logic pulse;
  } srl_pgen_state_type;

endpackage

//--- testbench/set_reset_latch_unit_test.sv
// self-checking bench for the set-reset latch unit: registers, firmware pulses,
// source enables, output routing and the periodic pulse divider.
// assumes srl_top with its default address width and the shared params header.
`timescale 1ns/1ns
`default_nettype none
`include "srl_params.svh"

module set_reset_latch_unit_test
  import srl_pkg::*;
;
  // ****************************************************************
  // signals, table and compare helpers
  // ****************************************************************
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] rexp;
    logic eexp;
  } srl_row_type;

  localparam srl_row_type rows [8] = '{
    '{12'h000, 32'h0000007c, 32'h0000007c, 1'b0},
    '{12'h000, 32'h00000003, 32'h00000000, 1'b0},
    '{12'h000, 32'h000000ff, 32'h000000fc, 1'b0},
    '{12'h004, 32'h000000a5, 32'h000000a5, 1'b0},
    '{12'h004, 32'h0000005a, 32'h0000005a, 1'b0},
    '{12'h004, 32'h00000000, 32'h00000000, 1'b0},
    '{12'h00c, 32'h00000011, 32'h00000000, 1'b1},
    '{12'h000, 32'h00000000, 32'h00000000, 1'b0}};

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic lpin, cmp1, cmp2, tq, tq_drv, cq, cq_drv, lat;
  int fails, comparisons;

  srl_top u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .latch_input_pin(lpin), .cmp1_out(cmp1), .cmp2_out(cmp2),
    .true_output_pin(tq), .true_output_drive(tq_drv), .complement_output_pin(cq),
    .complement_output_drive(cq_drv), .latch_state(lat));

  // 10 mhz clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_cnt(input string nm, input int exp, input int got);
    comparisons++;
    if (got != exp) begin
      fails++;
      $display("[FAIL] %s expected %0d seen %0d", nm, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************************************
  // apb master: setup, access held until pready seen, then release
  // ****************************************************************
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // pready, prdata and pslverr are taken at the rising edge that completes the access
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk_val("pready", 32'h1, 32'h0);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk_val(nm, exp, r);
  endtask

  task automatic settle();
    repeat (10) @(posedge pclk);
  endtask

  // counts negedges until the latch shows level v
  task automatic wait_lat(input logic v, output int n);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (lat !== v && n < 1100);
    if (n >= 1100) chk_val("latch wait", 32'(v), 32'(lat));
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [31:0] r;
    logic e, is_set;
    int k, wid, hi;
    fails = 0;
    comparisons = 0;
    {psel, penable, pwrite, lpin, cmp1, cmp2} = '0;
    paddr = '0;
    pwdata = '0;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("ctrl reset", `SRL_OFS_CTRL, 32'h0);
    rd_chk("src reset", `SRL_OFS_SRC, 32'h0);
    $display("test reset done");
    // force the latch to a known level before any output is routed out
    wr(`SRL_OFS_CTRL, 32'h81);

    // register table rows: write then read back
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      apb(1'b0, rows[i].addr, 32'h0, r, e);
      chk_val($sformatf("row %0d data", i), rows[i].rexp, r);
      chk_val($sformatf("row %0d error", i), 32'(rows[i].eexp), 32'(e));
    end
    $display("test register rows done");

    // firmware pulses, reset dominance and output routing
    wr(`SRL_OFS_CTRL, 32'h8e);
    settle();
    chk_val("latch after set", 32'h1, 32'(lat));
    chk_val("true pin", 32'h1, 32'(tq));
    chk_val("complement pin", 32'h0, 32'(cq));
    chk_val("both drives", 32'h3, {30'h0, tq_drv, cq_drv});
    rd_chk("status", `SRL_OFS_STAT, 32'h1);
    wr(`SRL_OFS_CTRL, 32'h8f);
    settle();
    chk_val("latch set and reset", 32'h0, 32'(lat));
    wr(`SRL_OFS_CTRL, 32'h8e);
    settle();
    wr(`SRL_OFS_CTRL, 32'h8d);
    settle();
    chk_val("latch after reset", 32'h0, 32'(lat));
    chk_val("complement pin high", 32'h1, 32'(cq));
    wr(`SRL_OFS_CTRL, 32'h88);
    settle();
    chk_val("true drive only", 32'h2, {30'h0, tq_drv, cq_drv});
    wr(`SRL_OFS_CTRL, 32'h84);
    settle();
    chk_val("complement drive only", 32'h1, {30'h0, tq_drv, cq_drv});
    wr(`SRL_OFS_CTRL, 32'h0e);
    settle();
    chk_val("drives when disabled", 32'h0, {30'h0, tq_drv, cq_drv});
    $display("test firmware and outputs done");

    // each source enable bit: no effect while off, acts when on
    for (int b = 0; b < 8; b++) begin
      is_set = (b >= 4);
      k = b % 4;
      wr(`SRL_OFS_CTRL, is_set ? 32'h81 : 32'h82);
      settle();
      @(posedge pclk);
      lpin <= (k == 3);
      cmp2 <= (k == 1);
      cmp1 <= (k == 0);
      settle();
      chk_val($sformatf("source %0d off", b), 32'(!is_set), 32'(lat));
      wr(`SRL_OFS_SRC, 32'h1 << b);
      settle();
      chk_val($sformatf("source %0d on", b), 32'(is_set), 32'(lat));
      @(posedge pclk);
      {lpin, cmp1, cmp2} <= 3'b000;
      wr(`SRL_OFS_SRC, 32'h0);
    end
    $display("test source enables done");

    // pin holds set, each divider pulse resets: latch dips once per period
    wr(`SRL_OFS_SRC, 32'h84);
    @(posedge pclk);
    lpin <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      wr(`SRL_OFS_CTRL, 32'h80 | (32'(s) << 4));
      wait_lat(1'b0, k);
      wait_lat(1'b1, k);
      wait_lat(1'b0, k);
      wait_lat(1'b1, wid);
      wait_lat(1'b0, hi);
      chk_cnt($sformatf("pulse width sel %0d", s), 1, wid);
      chk_cnt($sformatf("pulse period sel %0d", s), 4 << s, wid + hi);
    end
    $display("test divider periods done");

    // mid-run reset: routing drops at once, registers return to reset values
    wr(`SRL_OFS_CTRL, 32'h8c);
    settle();
    chk_val("drives before reset", 32'h3, {30'h0, tq_drv, cq_drv});
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk_val("drives in reset", 32'h0, {30'h0, tq_drv, cq_drv});
    presetn <= 1'b1;
    rd_chk("ctrl after reset", `SRL_OFS_CTRL, 32'h0);
    rd_chk("src after reset", `SRL_OFS_SRC, 32'h0);
    $display("test mid-run reset done");
    end_sim();
  end

  // watchdog well beyond the expected run of about 4000 cycles
  initial begin
    repeat (40000) @(posedge pclk);
    fails++;
    $display("[FAIL] watchdog expected finish seen timeout");
    end_sim();
  end
endmodule // set_reset_latch_unit_test

`default_nettype wire
